// >>> hw/ahpc_pkg.sv
// package for the atx host power control block
// assumes a 40 MHz clock and a 32-bit avalon-mm register port
package ahpc_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned TICK_HZ        = 32;            // 1/32 s ticks
   localparam int unsigned TICK_DIV       = CLK_HZ / TICK_HZ;
   localparam int unsigned ON_HOLD_MS     = 250;
   localparam int unsigned LONG_HOLD_MS   = 4000;
   localparam int unsigned EXTRA_MAX_MS   = 5000;
   localparam int unsigned RESET_PULSE_MS = 1000;
   localparam int unsigned MS_PER_S       = 1000;
   // tick counts derived from the times above
   localparam int unsigned ON_HOLD_TK   = (ON_HOLD_MS * TICK_HZ + MS_PER_S - 1) / MS_PER_S;
   localparam int unsigned LONG_HOLD_TK = (LONG_HOLD_MS * TICK_HZ + MS_PER_S - 1) / MS_PER_S;
   localparam int unsigned EXTRA_MAX_TK = (EXTRA_MAX_MS * TICK_HZ) / MS_PER_S;
   localparam int unsigned RESET_TK     = (RESET_PULSE_MS * TICK_HZ + MS_PER_S - 1) / MS_PER_S;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_PULSE  = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_FAN    = 4'hc;
   localparam logic [7:0] PULSE_RST  = 8'h20;            // 32 ticks = 1.0 s
   localparam logic [7:0] FAN_RST    = 8'hff;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

   // control register fields
   localparam int CTRL_PON_EN   = 0;
   localparam int CTRL_HOFF_EN  = 1;
   localparam int CTRL_HRST_EN  = 2;
   localparam int CTRL_PWR_INV  = 3;
   localparam int CTRL_RST_INV  = 4;
   localparam int CTRL_BLANK_EN = 5;
   localparam int CTRL_W        = 6;

   typedef struct packed {
      logic pwr_oe;
      logic pwr_out;
      logic rst_oe;
      logic rst_out;
   } ahpc_drive_t;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_HOLD  = 6'b000010,
      ST_PON   = 6'b000100,
      ST_POFF  = 6'b001000,
      ST_EXTRA = 6'b010000,
      ST_HRST  = 6'b100000
   } ahpc_state_t;
endpackage

// >>> hw/ahpc_top.sv
// atx host power control: keypad driven power on, hard off and reset
// assumes keys and power sense are raw pins, avalon-mm master on clk
`timescale 1ns/1ps

module ahpc_top
   import ahpc_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_DIV
)(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        key_check_n,
   input  wire logic        key_cancel_n,
   input  wire logic        pwr_sense,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             pwr_ctl_o,
   output logic             pwr_ctl_oe,
   output logic             host_rst_o,
   output logic             host_rst_oe,
   output logic             display_blank,
   output logic [7:0]       fan_power,
   output logic             self_reboot
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_q <= 3'h3;
         sync2_q <= 3'h3;
      end
      else
      begin
         sync1_q <= {pwr_sense, key_cancel_n, key_check_n};
         sync2_q <= sync1_q;
      end
   end
   logic chk_k;
   logic cnl_k;
   logic sense_s;
   assign chk_k   = ~sync2_q[0];
   assign cnl_k   = ~sync2_q[1];
   assign sense_s = sync2_q[2];

   // ---------------------------------------------------------------
   // 1/32 s tick divider
   // ---------------------------------------------------------------
   logic [31:0] div_q;
   logic [31:0] div_d;
   logic        tick;
   assign tick = (div_q == TICK_CYCLES - 1);
   always_comb
   begin
      div_d = tick ? 32'h0 : div_q + 32'h1;
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         div_q <= 32'h0;
      else
         div_q <= div_d;
   end

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl_q;
   logic [CTRL_W-1:0] ctrl_d;
   logic [7:0]        pulse_q;
   logic [7:0]        pulse_d;
   logic [7:0]        fan_q;
   logic [7:0]        fan_d;
   logic [31:0]       rdata_d;
   logic              ack_q;
   logic              ack_d;
   logic              wait_d;
   ahpc_state_t       st_q;
   logic              reboot_q;
   // one wait cycle per access: request seen, then acked
   // writes land only at the edge where waitrequest is seen low
   always_comb
   begin
      ctrl_d  = ctrl_q;
      pulse_d = pulse_q;
      fan_d   = fan_q;
      ack_d   = (avs_read || avs_write) && !ack_q;
      wait_d  = !ack_d;       // kept in a flop so the port has no logic after it
      rdata_d = avs_readdata;
      if (avs_write && ack_q)
      begin
         unique case (avs_address)
            REG_CTRL:  ctrl_d = avs_writedata[CTRL_W-1:0];
            REG_PULSE: pulse_d = avs_writedata[7:0];
            REG_FAN:   fan_d = avs_writedata[7:0];
            default:   ;
         endcase
      end
      if (avs_read && !ack_q)
      begin
         unique case (avs_address)
            REG_CTRL:   rdata_d = {26'h0, ctrl_q};
            REG_PULSE:  rdata_d = {24'h0, pulse_q};
            REG_STATUS: rdata_d = {24'h0, 2'h0, st_q};
            REG_FAN:    rdata_d = {24'h0, fan_q};
            default:    rdata_d = UNMAPPED_RD;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl_q       <= '0;
         pulse_q      <= PULSE_RST;
         fan_q        <= FAN_RST;
         ack_q        <= 1'b0;
         avs_readdata <= 32'h0;
         avs_waitrequest <= 1'b1;
      end
      else
      begin
         ctrl_q       <= ctrl_d;
         pulse_q      <= pulse_d;
         fan_q        <= fan_d;
         ack_q        <= ack_d;
         avs_readdata <= rdata_d;
         avs_waitrequest <= wait_d;
      end
   end

   // ---------------------------------------------------------------
   // key hold and pulse sequencer
   // ---------------------------------------------------------------
   ahpc_state_t st_d;
   logic [7:0]  cnt_q;
   logic [7:0]  cnt_d;
   logic        act_q;                // 1: hold was cancel key
   logic        act_d;
   logic        reboot_d;
   logic        any_key;
   assign any_key = act_q ? cnl_k : chk_k;
   always_comb
   begin
      st_d     = st_q;
      cnt_d    = cnt_q;
      act_d    = act_q;
      reboot_d = 1'b0;
      unique case (st_q)
         ST_IDLE:
         begin
            cnt_d = 8'h0;
            if (chk_k && !sense_s && ctrl_q[CTRL_PON_EN])
            begin
               st_d  = ST_HOLD;
               act_d = 1'b0;
            end
            else if (chk_k && sense_s && ctrl_q[CTRL_HRST_EN])
            begin
               st_d  = ST_HOLD;
               act_d = 1'b0;
            end
            else if (cnl_k && sense_s && ctrl_q[CTRL_HOFF_EN])
            begin
               st_d  = ST_HOLD;
               act_d = 1'b1;
            end
         end
         ST_HOLD:
         begin
            if (!any_key)
               st_d = ST_IDLE;
            else if (tick)
            begin
               cnt_d = cnt_q + 8'h1;
               // enables and sense rechecked: a mode switched off mid-hold never fires
               if (!act_q && !sense_s && ctrl_q[CTRL_PON_EN] && cnt_q + 8'h1 >= 8'(ON_HOLD_TK))
               begin
                  st_d  = ST_PON;
                  cnt_d = 8'h0;
               end
               else if (!act_q && sense_s && ctrl_q[CTRL_HRST_EN] && cnt_q + 8'h1 >= 8'(LONG_HOLD_TK))
               begin
                  st_d  = ST_HRST;
                  cnt_d = 8'h0;
               end
               else if (act_q && sense_s && ctrl_q[CTRL_HOFF_EN] && cnt_q + 8'h1 >= 8'(LONG_HOLD_TK))
               begin
                  st_d  = ST_POFF;
                  cnt_d = 8'h0;
               end
            end
         end
         ST_PON:
         begin
            if (tick)
               cnt_d = cnt_q + 8'h1;
            if (tick && cnt_q + 8'h1 >= pulse_q)
               st_d = ST_IDLE;
         end
         ST_POFF:
         begin
            if (tick)
               cnt_d = cnt_q + 8'h1;
            if (tick && cnt_q + 8'h1 >= pulse_q)
            begin
               st_d  = cnl_k ? ST_EXTRA : ST_IDLE;
               cnt_d = 8'h0;
            end
         end
         ST_EXTRA:
         begin
            if (tick)
               cnt_d = cnt_q + 8'h1;
            // bounded so a stuck key cannot hold the switch forever
            if (!cnl_k || (tick && cnt_q + 8'h1 >= 8'(EXTRA_MAX_TK)))
               st_d = ST_IDLE;
         end
         ST_HRST:
         begin
            if (tick)
               cnt_d = cnt_q + 8'h1;
            if (tick && cnt_q + 8'h1 >= 8'(RESET_TK))
            begin
               st_d     = ST_IDLE;
               reboot_d = 1'b1;
            end
         end
      endcase
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q     <= ST_IDLE;
         cnt_q    <= 8'h0;
         act_q    <= 1'b0;
         reboot_q <= 1'b0;
      end
      else
      begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         act_q    <= act_d;
         reboot_q <= reboot_d;
      end
   end
   assign self_reboot = reboot_q;

   // ---------------------------------------------------------------
   // pin drive, blanking and fan hold, all registered
   // ---------------------------------------------------------------
   ahpc_drive_t drv_q;
   ahpc_drive_t drv_d;
   logic        blank_q;
   logic        blank_d;
   logic [7:0]  fanout_q;
   logic [7:0]  fanout_d;
   always_comb
   begin
      drv_d.pwr_oe  = (st_d == ST_PON) || (st_d == ST_POFF) || (st_d == ST_EXTRA);
      drv_d.pwr_out = ctrl_q[CTRL_PWR_INV];
      drv_d.rst_oe  = (st_d == ST_HRST);
      drv_d.rst_out = ctrl_q[CTRL_RST_INV];
      blank_d       = ctrl_q[CTRL_BLANK_EN] && !sense_s;
      fanout_d      = fan_q;   // sense does not touch fans
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         drv_q    <= '0;
         blank_q  <= 1'b0;
         fanout_q <= FAN_RST;
      end
      else
      begin
         drv_q    <= drv_d;
         blank_q  <= blank_d;
         fanout_q <= fanout_d;
      end
   end
   assign pwr_ctl_o     = drv_q.pwr_out;
   assign pwr_ctl_oe    = drv_q.pwr_oe;
   assign host_rst_o    = drv_q.rst_out;
   assign host_rst_oe   = drv_q.rst_oe;
   assign display_blank = blank_q;
   assign fan_power     = fanout_q;
endmodule

// >>> verif/ahpc_mobo.sv
// motherboard switch inputs seen from the block's pins
// assumes pull-ups on both switch inputs
`timescale 1ns/1ps
module ahpc_mobo (
   input  wire logic pwr_ctl_o,
   input  wire logic pwr_ctl_oe,
   input  wire logic host_rst_o,
   input  wire logic host_rst_oe,
   output logic      pwr_pin,
   output logic      rst_pin
);
   // released pins float up, never hold the last level
   assign pwr_pin = pwr_ctl_oe ? pwr_ctl_o : 1'b1;
   assign rst_pin = host_rst_oe ? host_rst_o : 1'b1;
endmodule

// >>> verif/ahpc_sva.sv
// checker for the atx host power control block
// assumes a bind onto ahpc_top, sees only its ports
`timescale 1ns/1ps
module ahpc_sva
   import ahpc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        key_check_n,
   input wire logic        key_cancel_n,
   input wire logic        pwr_sense,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        pwr_ctl_o,
   input wire logic        pwr_ctl_oe,
   input wire logic        host_rst_o,
   input wire logic        host_rst_oe,
   input wire logic        display_blank,
   input wire logic [7:0]  fan_power,
   input wire logic        self_reboot
);
   logic [5:0] ctl_d;
   logic [5:0] ctl_q;

   // shadow of control, only completed writes count
   always_comb
   begin
      ctl_d = ctl_q;
      if (avs_write && !avs_waitrequest && avs_address == REG_CTRL)
         ctl_d = avs_writedata[5:0];
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ctl_q <= 6'h00;
      else
         ctl_q <= ctl_d;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // pin level is registered one edge after the control register
   pwr_level_a: assert property (pwr_ctl_oe |-> pwr_ctl_o == $past(ctl_q[3]))
      else $error("power pin level wrong");
   rst_level_a: assert property (host_rst_oe |-> host_rst_o == $past(ctl_q[4]))
      else $error("reset pin level wrong");
   pwr_quiet_a: assert property (!ctl_q[0] && !ctl_q[1] |-> !$rose(pwr_ctl_oe))
      else $error("power pin driven while disabled");
   reboot_after_a: assert property ($fell(host_rst_oe) |-> ##[0:4] self_reboot)
      else $error("no reboot after host reset");
   blank_on_a: assert property ((ctl_q[5] && !pwr_sense) [*4] |=> display_blank)
      else $error("display not blanked");
   fan_hold_a: assert property ((!avs_write) [*2] |=> $stable(fan_power))
      else $error("fan setting moved");
   bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered");
   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
endmodule

bind ahpc_top ahpc_sva u_sva (
   .clk             (clk),
   .rstn            (rstn),
   .key_check_n     (key_check_n),
   .key_cancel_n    (key_cancel_n),
   .pwr_sense       (pwr_sense),
   .avs_address     (avs_address),
   .avs_read        (avs_read),
   .avs_write       (avs_write),
   .avs_writedata   (avs_writedata),
   .avs_readdata    (avs_readdata),
   .avs_waitrequest (avs_waitrequest),
   .pwr_ctl_o       (pwr_ctl_o),
   .pwr_ctl_oe      (pwr_ctl_oe),
   .host_rst_o      (host_rst_o),
   .host_rst_oe     (host_rst_oe),
   .display_blank   (display_blank),
   .fan_power       (fan_power),
   .self_reboot     (self_reboot)
);

// >>> verif/atx_host_power_control_test.sv
// testbench for the atx host power control block
// assumes ahpc_top, the checker bind and the board model
`timescale 1ns/1ps
module atx_host_power_control_test;
   import ahpc_pkg::*;
   localparam int T = 4; // short tick keeps 4 s holds cheap
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        key_check_n = 1'b1;
   logic        key_cancel_n = 1'b1;
   logic        pwr_sense = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic [31:0] rd;
   logic        avs_waitrequest;
   logic        pwr_ctl_o;
   logic        pwr_ctl_oe;
   logic        host_rst_o;
   logic        host_rst_oe;
   logic        display_blank;
   logic        self_reboot;
   logic        pwr_pin;
   logic        rst_pin;
   logic [7:0]  fan_power;
   int          num_errors = 0;
   int          compares = 0;
   int          d;

   always #12.5 clk = ~clk;

   // pins stay in default drive except in t_hoff, which inverts the power pin
   ahpc_top #(.TICK_CYCLES(T)) uut (
      .clk             (clk),
      .rstn            (rstn),
      .key_check_n     (key_check_n),
      .key_cancel_n    (key_cancel_n),
      .pwr_sense       (pwr_sense),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .pwr_ctl_o       (pwr_ctl_o),
      .pwr_ctl_oe      (pwr_ctl_oe),
      .host_rst_o      (host_rst_o),
      .host_rst_oe     (host_rst_oe),
      .display_blank   (display_blank),
      .fan_power       (fan_power),
      .self_reboot     (self_reboot)
   );
   ahpc_mobo mobo (
      .pwr_ctl_o   (pwr_ctl_o),
      .pwr_ctl_oe  (pwr_ctl_oe),
      .host_rst_o  (host_rst_o),
      .host_rst_oe (host_rst_oe),
      .pwr_pin     (pwr_pin),
      .rst_pin     (rst_pin)
   );

   task stop_test;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask

   task rng(input int v, input int lo, input int hi);
      compares++;
      if (v < lo || v > hi)
      begin
         num_errors++;
         $display("BAD %0t count %0d not in %0d..%0d", $time, v, lo, hi);
      end
   endtask

   // one avalon access, held until waitrequest is seen low
   task bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      // waitrequest read right after the edge is the value sampled there
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
      begin
         n++;
         if (n > 64)
         begin
            num_errors++;
            stop_test;
         end
         @(posedge clk);
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // cycles until the chosen enable equals v; must = a hang is fatal
   task owait(input bit r, input logic v, input int lim, input bit must, output int n);
      n = 0;
      while ((r ? host_rst_oe : pwr_ctl_oe) !== v && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      if (must && n >= lim)
      begin
         num_errors++;
         stop_test;
      end
   endtask

   task t_regs;
      chk(pwr_pin, 1'b1);
      chk(rst_pin, 1'b1);
      bus(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, REG_PULSE, 32'h0);
      chk(rd, 32'h20);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd, 32'h1);
      bus(1'b0, REG_FAN, 32'h0);
      chk(rd, 32'hff);
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
   endtask

   // early release must restart the count
   task t_pon;
      bus(1'b1, REG_PULSE, 32'h4);
      bus(1'b0, REG_PULSE, 32'h0);
      chk(rd, 32'h4);
      bus(1'b1, REG_CTRL, 32'h1);
      bus(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h1);
      @(posedge clk) key_check_n <= 1'b0;
      owait(0, 1'b1, 5 * T, 0, d);
      @(posedge clk) key_check_n <= 1'b1;
      chk(pwr_ctl_oe, 1'b0);
      repeat (4 * T) @(posedge clk);
      key_check_n <= 1'b0;
      owait(0, 1'b1, 60, 1, d);
      rng(d, 7 * T, 8 * T + 6);
      chk(pwr_pin, 1'b0);
      @(posedge clk) key_check_n <= 1'b1;
      owait(0, 1'b0, 40, 1, d);
      rng(d, 4 * T - 2, 4 * T);
   endtask

   task t_off;
      bus(1'b1, REG_CTRL, 32'h6);
      @(posedge clk) key_check_n <= 1'b0;
      owait(0, 1'b1, 12 * T, 0, d);
      rng(d, 12 * T, 12 * T);
      @(posedge clk) key_check_n <= 1'b1;
   endtask

   task t_blank;
      bus(1'b1, REG_CTRL, 32'h20);
      bus(1'b1, REG_FAN, 32'h5a);
      repeat (8) @(posedge clk);
      chk(display_blank, 1'b1);
      pwr_sense <= 1'b1;
      repeat (8) @(posedge clk);
      chk(display_blank, 1'b0);
      chk(fan_power, 8'h5a);
      // host drops: blank again, fans untouched
      pwr_sense <= 1'b0;
      repeat (8) @(posedge clk);
      chk(display_blank, 1'b1);
      chk(fan_power, 8'h5a);
      pwr_sense <= 1'b1;
      repeat (8) @(posedge clk);
   endtask

   // cancel kept held stretches the pulse to its cap
   task t_hoff;
      bus(1'b1, REG_CTRL, 32'ha);
      @(posedge clk) key_cancel_n <= 1'b0;
      owait(0, 1'b1, 600, 1, d);
      rng(d, 127 * T, 128 * T + 6);
      chk(pwr_ctl_o, 1'b1);
      owait(0, 1'b0, 800, 1, d);
      rng(d, 163 * T, 165 * T);
      @(posedge clk) key_cancel_n <= 1'b1;
      // second round: key let go during the stretch ends it early
      repeat (8) @(posedge clk);
      key_cancel_n <= 1'b0;
      owait(0, 1'b1, 600, 1, d);
      rng(d, 127 * T, 128 * T + 6);
      repeat (8 * T) @(negedge clk);
      @(posedge clk) key_cancel_n <= 1'b1;
      owait(0, 1'b0, 40, 1, d);
      rng(d, 2, 6);
   endtask

   task t_hrst;
      bus(1'b1, REG_CTRL, 32'h4);
      @(posedge clk) key_check_n <= 1'b0;
      owait(1, 1'b1, 600, 1, d);
      rng(d, 127 * T, 128 * T + 6);
      chk(rst_pin, 1'b0);
      @(posedge clk) key_check_n <= 1'b1;
      owait(1, 1'b0, 200, 1, d);
      rng(d, 32 * T - 2, 32 * T);
      d = 0;
      while (self_reboot !== 1'b1 && d < 8)
      begin
         @(negedge clk);
         d++;
      end
      rng(d, 0, 7);
      @(posedge clk) rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      bus(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h0);
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_regs;
      t_pon;
      t_off;
      t_blank;
      t_hoff;
      t_hrst;
      stop_test;
   end
endmodule
